// ---- sah_consts.svh ----
// Constants of the converter host interface: offsets, field positions, timing.
// Assumes a 250 MHz clk; included by bare name from sah_sar, sah_top and the bench.
//
// Overview of operation
// (R1) Convert start with byte_sel_short_cycle low resolves all twelve bits.
// (R2) Convert start with byte_sel_short_cycle high resolves only eight bits.
// (R3) Byte read, width select low, byte select low: upper eight bits on lines 11..4.
// (R4) Byte format: result_upper_nibble carries bits 11..8 when low, floats when high.
// (R5) Byte format: result_middle_nibble carries bits 7..4 when low, zeros when high.
// (R6) Byte format: result_lower_nibble carries bits 3..0 when high, floats when low.
// (R7) Width select high gives full 12-bit word; low gives two byte reads.
// (R8) Active-high enable strobe from host triggers a convert or a read.
// (R9) Select input is active low; host holds it low to address device.
// (R10) Full control: read_conv high requests read, low requests conversion start.
// (R11) Stand-alone: falling read_conv starts a new conversion.
// (R12) conversion_busy high during conversion, low once complete.
// (R13) During conversion, starts are ignored and no result data is driven.
// (R14) At end: stop bit clock, sampler tracks, delay busy fall for acquisition.
// (R15) Full control: request accepted only while select low and enable high.
`ifndef SAH_CONSTS_SVH
`define SAH_CONSTS_SVH

`define SAH_CLK_MHZ 250
`define SAH_BIT_NS 640
`define SAH_BIT_CYC ((`SAH_BIT_NS * `SAH_CLK_MHZ + 999) / 1000)
`define SAH_ACQ_NS 600
`define SAH_ACQ_CYC ((`SAH_ACQ_NS * `SAH_CLK_MHZ + 999) / 1000)

`define SAH_RES_BITS 12
`define SAH_MSB_IDX 4'hB
`define SAH_SHORT_LAST 4'h4
`define SAH_FULL_LAST 4'h0

`define SAH_OFF_CTRL 8'h00
`define SAH_OFF_STAT 8'h04
`define SAH_OFF_RES 8'h08
`define SAH_OFF_ISR 8'h0C
`define SAH_OFF_IMR 8'h10

`define SAH_CTRL_STANDALONE 0
`define SAH_CTRL_RST 1'h0
`define SAH_STAT_BUSY 0
`define SAH_STAT_CONV 1
`define SAH_STAT_SHORT 2
`define SAH_IRQ_DONE 0
`define SAH_IRQ_IGN 1
`define SAH_IRQ_RST 2'h0

`define SAH_RESP_OKAY 2'h0
`define SAH_RESP_SLVERR 2'h2

`endif

// ---- sah_pkg.sv ----
// Types shared by the converter host interface modules.
// Assumes sah_consts.svh is on the include path.
`default_nettype none
package sah_pkg;
  // ==========================================
  // Control sequence states
  typedef enum logic [1:0] {SAH_IDLE, SAH_CONV, SAH_ACQ} sah_state_t;
  typedef logic [11:0] sah_word_t;
endpackage : sah_pkg
`default_nettype wire

// ---- sah_sar_if.sv ----
// Link between the control sequencer and the successive-approximation engine.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface sah_sar_if;
  logic start;
  logic short_cyc;
  logic active;
  logic done;
  logic [11:0] code;
  modport ctl (output start, output short_cyc, input active, input done, input code);
  modport sar (input start, input short_cyc, output active, output done, output code);
endinterface : sah_sar_if
`default_nettype wire

// ---- sah_sar.sv ----
// Successive-approximation engine: bit clock divider, trial code, bit decisions.
// Assumes an external comparator answers the trial code within one bit period.
`include "sah_consts.svh"
`default_nettype none
module sah_sar
(
  input wire logic clk,
  input wire logic sys_rst,
  sah_sar_if.sar sar,
  input wire logic cmp_above,
  output logic [11:0] dac_code
);
  import sah_pkg::*;

  localparam logic [7:0] BIT_LAST = 8'(`SAH_BIT_CYC - 1);

  logic [7:0] div_q;
  logic [3:0] idx_q;
  logic short_q;
  logic active_q;
  logic done_q;
  sah_word_t code_q;
  logic tick;

  // ==========================================
  // Bit clock: runs only while converting, so it stops at the end
  assign tick = active_q && (div_q == BIT_LAST);

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      div_q <= 8'h00;
    else if (!active_q || tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;

  // ==========================================
  // Bit decisions, MSB first; short cycles stop after bit 4
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      active_q <= 1'b0;
      done_q <= 1'b0;
      short_q <= 1'b0;
      idx_q <= 4'h0;
      code_q <= 12'h000;
    end
    else
    begin
      done_q <= 1'b0;
      if (sar.start && !active_q)
      begin
        active_q <= 1'b1;
        short_q <= sar.short_cyc; // R2
        idx_q <= `SAH_MSB_IDX;
        code_q <= 12'h000;
      end
      else if (tick)
      begin
        code_q[idx_q] <= cmp_above;
        if (idx_q == (short_q ? `SAH_SHORT_LAST : `SAH_FULL_LAST)) // R1 R2
        begin
          active_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          idx_q <= idx_q - 4'h1;
      end
    end

  // Trial level: decided bits plus the bit under test
  always_comb
  begin
    dac_code = code_q;
    if (active_q)
      dac_code[idx_q] = 1'b1;
  end

  assign sar.active = active_q;
  assign sar.done = done_q;
  assign sar.code = code_q;

  // ==========================================
  // Checks
  property p_short_low_zero;
    @(posedge clk) disable iff (sys_rst)
      (done_q && short_q) |-> (code_q[3:0] == 4'h0);
  endproperty
  a_short_low_zero: assert property (p_short_low_zero) // R2
    else $error("short cycle left low bits set");
endmodule : sah_sar
`default_nettype wire

// ---- sah_top.sv ----
// Top of the converter host interface: pin protocol, sequencing, output
// formatting, AXI4-Lite registers and interrupt.
// Assumes host pins are synchronous to clk; the board resolves the data lines.
`include "sah_consts.svh"
`default_nettype none
module sah_top
(
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host pins
  input wire logic chip_enable,
  input wire logic select_n,
  input wire logic read_conv,
  input wire logic byte_sel_short_cycle,
  input wire logic width_12_sel,
  output logic [11:0] data_o,
  output logic [11:0] data_oe,
  output logic conversion_busy,
  // Analog boundary and interrupt
  input wire logic cmp_above,
  output logic [11:0] dac_code,
  output logic sample_hold,
  output logic irq
);
  import sah_pkg::*;

  localparam int ACQ_M = `SAH_ACQ_CYC - 1;
  localparam logic [7:0] ACQ_LAST = 8'(`SAH_ACQ_CYC - 1);

  sah_sar_if sar_link ();

  sah_state_t st_q;
  logic standalone_q;
  logic req_q;
  logic rc_q;
  logic busy_q;
  logic hold_q;
  logic run_short_q;
  logic [7:0] acq_q;
  sah_word_t result_q;
  logic [11:0] dout_q;
  logic [11:0] doe_q;
  logic [1:0] isr_q;
  logic [1:0] imr_q;
  logic irq_q;
  logic req;
  logic launch;
  logic sa_start;
  logic conv_req;
  logic accept;
  logic read_en;

  // ==========================================
  // Engine
  sah_sar u_sar
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .sar(sar_link),
    .cmp_above(cmp_above),
    .dac_code(dac_code)
  );

  // ==========================================
  // Host pin decode
  assign req = !select_n && chip_enable; // R9 R15
  assign launch = req && !req_q; // R8
  assign sa_start = rc_q && !read_conv; // R11
  // Full control: a launch with read_conv low is a convert
  assign conv_req = standalone_q ? sa_start : (launch && !read_conv); // R10
  assign accept = conv_req && (st_q == SAH_IDLE); // R13
  // Reads are allowed during acquisition, never while bits are resolved
  assign read_en = standalone_q ? read_conv : (req && read_conv); // R10 R15

  // Edge history of the launch condition and of read_conv
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      req_q <= 1'b0;
      rc_q <= 1'b0;
    end
    else
    begin
      req_q <= req;
      rc_q <= read_conv;
    end

  // ==========================================
  // Conversion sequence
  assign sar_link.start = accept;
  assign sar_link.short_cyc = byte_sel_short_cycle; // R1 R2

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      st_q <= SAH_IDLE;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      acq_q <= 8'h00;
      run_short_q <= 1'b0;
    end
    else
      case (st_q)
        SAH_IDLE:
          if (accept)
          begin
            st_q <= SAH_CONV;
            busy_q <= 1'b1; // R12
            hold_q <= 1'b1;
            run_short_q <= byte_sel_short_cycle;
          end
        SAH_CONV:
          if (sar_link.done)
          begin
            st_q <= SAH_ACQ;
            hold_q <= 1'b0; // R14
            acq_q <= 8'h00;
          end
        SAH_ACQ:
          // Busy falls only after the sampler has settled
          if (acq_q == ACQ_LAST)
          begin
            st_q <= SAH_IDLE;
            busy_q <= 1'b0; // R12 R14
          end
          else
            acq_q <= acq_q + 8'h01;
        default:
          st_q <= SAH_IDLE;
      endcase

  // Result capture at end of conversion
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      result_q <= 12'h000;
    else if (sar_link.done)
      result_q <= sar_link.code;

  // ==========================================
  // Data line formatting, registered
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      dout_q <= 12'h000;
      doe_q <= 12'h000;
    end
    else if (!read_en || st_q == SAH_CONV) // R13
    begin
      dout_q <= 12'h000;
      doe_q <= 12'h000;
    end
    else if (width_12_sel) // R7
    begin
      dout_q <= result_q;
      doe_q <= 12'hFFF;
    end
    else if (!byte_sel_short_cycle)
    begin
      dout_q <= {result_q[11:4], 4'h0}; // R3 R4 R5
      doe_q <= 12'hFF0; // R6
    end
    else
    begin
      dout_q <= {4'h0, 4'h0, result_q[3:0]}; // R5 R6
      doe_q <= 12'h0FF; // R4
    end

  assign data_o = dout_q;
  assign data_oe = doe_q;
  assign conversion_busy = busy_q;
  assign sample_hold = hold_q;

  // ==========================================
  // AXI4-Lite slave: address and data latched independently
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic do_wr;
  logic [1:0] isr_clr;
  logic [1:0] isr_set;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign do_wr = aw_full_q && w_full_q;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SAH_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        case (aw_addr_q)
          `SAH_OFF_CTRL, `SAH_OFF_STAT, `SAH_OFF_RES, `SAH_OFF_ISR, `SAH_OFF_IMR:
            bresp_q <= `SAH_RESP_OKAY;
          default:
            bresp_q <= `SAH_RESP_SLVERR;
        endcase
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end

  // Control and mask registers; only byte lane 0 carries fields
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      standalone_q <= `SAH_CTRL_RST;
      imr_q <= `SAH_IRQ_RST;
    end
    else if (do_wr && w_strb_q[0])
    begin
      if (aw_addr_q == `SAH_OFF_CTRL)
        standalone_q <= w_data_q[`SAH_CTRL_STANDALONE];
      if (aw_addr_q == `SAH_OFF_IMR)
        imr_q <= w_data_q[1:0];
    end

  // Sticky events; a set in the clearing cycle survives
  assign isr_clr = (do_wr && w_strb_q[0] && aw_addr_q == `SAH_OFF_ISR) ? w_data_q[1:0] : 2'h0;
  assign isr_set = {conv_req && !accept, sar_link.done};

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      isr_q <= `SAH_IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
      irq_q <= |(((isr_q & ~isr_clr) | isr_set) & imr_q);
    end

  assign irq = irq_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel: one read at a time, answer the cycle after the address
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SAH_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `SAH_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      case (s_axi_araddr)
        `SAH_OFF_CTRL: rdata_q[`SAH_CTRL_STANDALONE] <= standalone_q;
        `SAH_OFF_STAT: rdata_q[2:0] <= {run_short_q, st_q == SAH_CONV, busy_q};
        `SAH_OFF_RES: rdata_q[11:0] <= result_q;
        `SAH_OFF_ISR: rdata_q[1:0] <= isr_q;
        `SAH_OFF_IMR: rdata_q[1:0] <= imr_q;
        default: rresp_q <= `SAH_RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_busy_on_start;
    accept |=> conversion_busy && sample_hold && st_q == SAH_CONV;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) // R12
    else $error("busy not raised on accepted start");

  property p_no_data_conv;
    st_q == SAH_CONV ##1 st_q == SAH_CONV |-> data_oe == 12'h000;
  endproperty
  a_no_data_conv: assert property (p_no_data_conv) // R13
    else $error("data driven during conversion");

  property p_ignored;
    conv_req && st_q != SAH_IDLE |=> isr_q[`SAH_IRQ_IGN] && $stable(run_short_q);
  endproperty
  a_ignored: assert property (p_ignored) // R13
    else $error("start during busy not ignored");

  property p_word12;
    read_en && st_q != SAH_CONV && width_12_sel |=> data_oe == 12'hFFF && data_o == result_q;
  endproperty
  a_word12: assert property (p_word12) // R7
    else $error("12-bit word not presented");

  property p_high_byte;
    read_en && st_q != SAH_CONV && !width_12_sel && !byte_sel_short_cycle
      |=> data_oe == 12'hFF0 && data_o[11:4] == result_q[11:4];
  endproperty
  a_high_byte: assert property (p_high_byte) // R3
    else $error("high byte format wrong");

  property p_low_byte;
    read_en && st_q != SAH_CONV && !width_12_sel && byte_sel_short_cycle
      |=> data_oe == 12'h0FF && data_o[7:4] == 4'h0 && data_o[3:0] == result_q[3:0];
  endproperty
  a_low_byte: assert property (p_low_byte) // R5
    else $error("low byte format wrong");

  property p_acq_delay;
    sar_link.done |=> !sample_hold && conversion_busy ##ACQ_M conversion_busy
      ##1 !conversion_busy;
  endproperty
  a_acq_delay: assert property (p_acq_delay) // R14
    else $error("acquisition delay wrong");

  property p_no_select;
    !standalone_q && !req && st_q == SAH_IDLE |=> st_q == SAH_IDLE;
  endproperty
  a_no_select: assert property (p_no_select) // R15
    else $error("start without select and enable");

  property p_sa_fall;
    standalone_q && $fell(read_conv) && st_q == SAH_IDLE |=> conversion_busy;
  endproperty
  a_sa_fall: assert property (p_sa_fall) // R11
    else $error("stand-alone falling edge missed");

  property p_read_no_start;
    !standalone_q && launch && read_conv && st_q == SAH_IDLE |=> !conversion_busy;
  endproperty
  a_read_no_start: assert property (p_read_no_start) // R10
    else $error("read launched a conversion");

  c_short_done: cover property (sar_link.done && run_short_q);
  c_full_done: cover property (sar_link.done && !run_short_q);
  c_low_byte_read: cover property (doe_q == 12'h0FF);
endmodule : sah_top
`default_nettype wire

// ---- sah_cmp_model.sv ----
// Analog front end stand-in: sampler plus comparator facing the trial code.
// Assumes the design holds sample_hold high while it resolves bits.
`default_nettype none
module sah_cmp_model
(
  input wire logic clk,
  input wire logic sample_hold,
  input wire logic [11:0] level,
  input wire logic [11:0] dac_code,
  output logic cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held_q;
  // ==========================================
  // Sampler: tracks while open, frozen while held
  always_ff @(posedge clk)
    if (!sample_hold)
      held_q <= level;
  // Bit is kept when the held input reaches the trial code
  assign cmp_above = (held_q >= dac_code);
endmodule : sah_cmp_model
`default_nettype wire

// ---- sar_adc_host_interface_test.sv ----
// Self-checking bench for sah_top: host pins, AXI4-Lite registers, interrupt.
// Assumes sah_cmp_model stands in for the analog side.
`include "sah_consts.svh"
`default_nettype none
module sar_adc_host_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic chip_enable = 0, select_n = 1, read_conv = 0, byte_sel_short_cycle = 0;
  logic width_12_sel = 0;
  logic [11:0] data_o, data_oe, dac_code, res;
  logic conversion_busy, cmp_above, sample_hold, irq;
  logic [11:0] level = 12'h000;
  logic [11:0] oe_last = 12'h000;
  logic [33:0] axi_q[$];
  logic [23:0] pin_q[$];
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int t0 = 0;

  always #2 clk = ~clk;

  sah_top dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chip_enable, .select_n, .read_conv, .byte_sel_short_cycle, .width_12_sel,
    .data_o, .data_oe, .conversion_busy, .cmp_above, .dac_code, .sample_hold, .irq);

  sah_cmp_model front (.clk, .sample_hold, .level, .dac_code, .cmp_above);

  // ==========================================
  // Reporting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic timeout(input string what);
    error_cnt++;
    $display("BAD %s expected answer seen timeout", what);
    give_verdict();
  endtask : timeout

  // ==========================================
  // Watcher: takes the oldest note whenever a result appears
  always @(posedge clk)
  begin
    cyc++;
    if (s_axi_rvalid && s_axi_rready)
      check("rdata", axi_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (data_oe !== 12'h000 && oe_last === 12'h000)
    begin
      if (pin_q.size() != 0)
        check("data", {10'h0, pin_q.pop_front()}, {10'h0, data_oe, data_o & data_oe});
      else
        check("data_oe", 34'h0, {22'h0, data_oe});
    end
    else if (sample_hold && !select_n && chip_enable)
      check("data_oe_busy", 34'h0, {22'h0, data_oe});
    oe_last = data_oe;
  end

  // ==========================================
  // Bus tasks; each holds its strobes until the matching ready edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic done;
    logic [1:0] er;
    done = 1'b0;
    er = (a > `SAH_OFF_IMR) ? `SAH_RESP_SLVERR : `SAH_RESP_OKAY;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        check("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
      end
    end
    if (!done)
      timeout("bvalid");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    int i;
    logic done;
    done = 1'b0;
    axi_q.push_back(exp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      timeout("rvalid");
  endtask : axi_rd

  // Host pin cycle: select and modes first, then the enable strobe
  task automatic pin_op(input logic sel_n, input logic rc, input logic bs, input logic w12);
    @(posedge clk);
    select_n <= sel_n;
    read_conv <= rc;
    byte_sel_short_cycle <= bs;
    width_12_sel <= w12;
    @(posedge clk);
    chip_enable <= 1'b1;
    repeat (3) @(posedge clk);
    chip_enable <= 1'b0;
    select_n <= 1'b1;
    @(posedge clk);
  endtask : pin_op

  task automatic rd_pins(input logic bs, input logic w12, input logic [23:0] exp);
    pin_q.push_back(exp);
    pin_op(1'b0, 1'b1, bs, w12);
  endtask : rd_pins

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (conversion_busy !== lvl)
    begin
      @(posedge clk);
      n++;
      if (n > lim)
        timeout("conversion_busy");
    end
  endtask : wait_busy

  task automatic conv_start(input logic bs, input logic [11:0] v);
    level <= v;
    pin_op(1'b0, 1'b0, bs, 1'b1);
    wait_busy(1'b1, 8);
    t0 = cyc;
  endtask : conv_start

  // Busy length tells a full cycle from a short or restarted one
  task automatic conv_end(input int bits);
    int lo;
    lo = bits * `SAH_BIT_CYC;
    wait_busy(1'b0, 3000);
    check("busy_len", 34'h1, {33'h0, (cyc - t0 >= lo) && (cyc - t0 <= lo + 160)});
  endtask : conv_end

  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h57D2));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("reset", 34'h0, {20'h0, data_oe, conversion_busy, irq});
    res = 12'($urandom);
    conv_start(1'b0, res);
    conv_end(12);
    check("irq_masked", 34'h0, {33'h0, irq});
    rd_pins(1'b0, 1'b1, {12'hFFF, res});
    rd_pins(1'b0, 1'b0, {12'hFF0, res[11:4], 4'h0});
    rd_pins(1'b1, 1'b0, {12'h0FF, 8'h00, res[3:0]});
    axi_rd(`SAH_OFF_RES, {22'h0, res});
    axi_rd(`SAH_OFF_ISR, 34'h1);
    axi_wr(`SAH_OFF_IMR, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_set", 34'h1, {33'h0, irq});
    axi_wr(`SAH_OFF_ISR, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_clear", 34'h0, {33'h0, irq});
    axi_rd(8'h20, {2'h2, 32'h0});
    axi_wr(8'h20, 32'h0);
    $display("full conversion and reads done");
    // Short cycle; a read and a restart mid-conversion are refused
    res = 12'($urandom);
    conv_start(1'b1, res);
    repeat (200) @(posedge clk);
    axi_rd(`SAH_OFF_STAT, 34'h7);
    pin_op(1'b0, 1'b1, 1'b0, 1'b1);
    pin_op(1'b0, 1'b0, 1'b0, 1'b1);
    conv_end(8);
    rd_pins(1'b0, 1'b1, {12'hFFF, res[11:4], 4'h0});
    axi_rd(`SAH_OFF_ISR, 34'h3);
    axi_wr(`SAH_OFF_ISR, 32'h3);
    $display("short cycle and refusals done");
    // Enable strobe without select must not launch
    pin_op(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    check("no_launch", 34'h0, {33'h0, conversion_busy});
    $display("select gating done");
    // Stand-alone: falling read_conv starts a conversion
    axi_wr(`SAH_OFF_CTRL, 32'h1);
    // Raising read_conv in stand-alone mode reads out the previous short result
    pin_q.push_back({12'hFFF, res[11:4], 4'h0});
    res = 12'($urandom);
    level <= res;
    @(posedge clk);
    read_conv <= 1'b1;
    repeat (4) @(posedge clk);
    read_conv <= 1'b0;
    wait_busy(1'b1, 8);
    t0 = cyc;
    conv_end(12);
    check("irq_done", 34'h1, {33'h0, irq});
    axi_rd(`SAH_OFF_RES, {22'h0, res});
    axi_rd(`SAH_OFF_CTRL, 34'h1);
    axi_wr(`SAH_OFF_CTRL, 32'h0);
    $display("stand-alone done");
    give_verdict();
  end
endmodule : sar_adc_host_interface_test
`default_nettype wire
